// ===== gpib_pkg.sv
// Function
// - Setup switch one on selects addressable mode, answering controller commands.
// - Primary address 1 to 31, default 6; address 0 never used.
// - Address is the binary sum of switches four to eight that are off.
// - Switch one off at power-up selects talker-only mode with talk shown.
// - In talker-only mode a button press starts one measurement unless a reading is in progress.
// - Talker-only: result sent, listen flashed briefly, then next press awaited.
// - Send data only when addressed to talk or after a talker-only reading.
// - Accept device data only when addressed to listen.
// - Full three-wire handshake as source and as acceptor.
// - Device can pull the service request line.
// - No parallel poll, controller role or extended addressing.
// - Controller can switch the device between remote and local.
// - Device clear from the bus only sets the clear event for software; no interface state is reset.
// - A bus trigger command can start a measurement.
// - Bus lines are only pulled low or released, never driven high.
// - Remote indicator lit while under interface control.
// - Listen indicator lit while receiving bus data.
// - Talk indicator lit while transmitting, always in talker-only mode.
// - Local lockout ignores buttons, keeps remote control, shows lockout indicator.
package gpib_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LISTEN_PULSE_MS = 100;
  localparam int LISTEN_PULSE_CYC_DEF = (LISTEN_PULSE_MS * 1000000) / CLK_PERIOD_NS;
  localparam logic [1:0] SW_SETTLE_CYCLES = 2'h3;
  localparam logic [4:0] DEFAULT_ADDR = 5'h06;

  localparam int AXI_ADDR_W = 5;
  localparam logic [AXI_ADDR_W-1:0] OFF_CTRL = 5'h00;
  localparam logic [AXI_ADDR_W-1:0] OFF_STATUS = 5'h04;
  localparam logic [AXI_ADDR_W-1:0] OFF_TXDATA = 5'h08;
  localparam logic [AXI_ADDR_W-1:0] OFF_RXDATA = 5'h0C;
  localparam logic [AXI_ADDR_W-1:0] OFF_EVENTS = 5'h10;
  localparam logic [AXI_ADDR_W-1:0] OFF_SPOLL = 5'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int EV_TRIGGER = 0;
  localparam int EV_CLEAR = 1;
  localparam int EV_BUTTON = 2;
  localparam int EV_SENT = 3;

  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;

  // Control lines after synchronising, index into an 8-bit vector.
  localparam int L_ATN = 0;
  localparam int L_IFC = 1;
  localparam int L_REN = 2;
  localparam int L_DAV = 3;
  localparam int L_NRFD = 4;
  localparam int L_NDAC = 5;
  localparam int L_EOI = 6;
  localparam int L_BTN = 7;

  typedef struct packed {
    logic [7:0] dio;
    logic eoi;
    logic dav;
    logic nrfd;
    logic ndac;
    logic ifc;
    logic srq;
    logic atn;
    logic ren;
  } bus_lines_type;

  typedef struct packed {
    logic remote;
    logic listen;
    logic talk;
    logic lockout;
  } leds_type;

  typedef enum logic [0:0] {
    AH_READY = 1'b0,
    AH_HOLD = 1'b1
  } ah_state_type;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_SETTLE = 2'b01,
    SH_WAIT = 2'b10
  } sh_state_type;

endpackage

// ===== gpib_device_interface.sv
`timescale 1ns/1ps
module gpib_device_interface import gpib_pkg::*; #(
  parameter int unsigned LISTEN_PULSE_CYCLES = LISTEN_PULSE_CYC_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Bus pins, low-true levels as on the wire
  input wire bus_lines_type bus_in_n,
  output bus_lines_type bus_out,
  output bus_lines_type bus_oe,
  // Setup switches (bit 0 is switch one, high means on) and front-panel button
  input wire logic [7:0] setup_sw_on,
  input wire logic panel_button,
  // Status indicators
  output leds_type leds
);

  typedef struct packed {
    logic [7:0] ctl_s1;
    logic [7:0] ctl_s2;
    logic [7:0] dio_s1;
    logic [7:0] dio_s2;
    logic [7:0] sw_s1;
    logic [7:0] sw_s2;
    logic btn_prev;
    logic [1:0] boot_cnt;
    logic booted;
    logic talker_only;
    logic [4:0] my_addr;
    logic talk;
    logic listen;
    logic remote;
    logic lockout;
    logic spoll_mode;
    logic reading;
    logic srq_req;
    logic [7:0] spoll_byte;
    ah_state_type ah;
    sh_state_type sh;
    logic [7:0] settle_cnt;
    logic sh_is_poll;
    logic [23:0] pulse_cnt;
    logic [7:0] tx_data;
    logic tx_eoi;
    logic tx_full;
    logic [7:0] rx_data;
    logic rx_eoi;
    logic rx_full;
    logic [3:0] events;
    bus_lines_type oe;
    bus_lines_type lvl;
    leds_type led;
    logic awready;
    logic wready;
    logic arready;
    logic aw_got;
    logic w_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_type;

  state_type q;
  state_type d;

  logic atn;
  logic ifc;
  logic ren;
  logic dav;
  logic nrfd;
  logic ndac;
  logic btn_press;
  logic [6:0] cmd;
  logic ah_active;
  logic data_send_ok;
  logic poll_send_ok;
  logic [4:0] sw_addr;
  logic [3:0] ev_set;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised line levels, all true when asserted.

  assign atn = q.ctl_s2[L_ATN];
  assign ifc = q.ctl_s2[L_IFC];
  assign ren = q.ctl_s2[L_REN];
  assign dav = q.ctl_s2[L_DAV];
  assign nrfd = q.ctl_s2[L_NRFD];
  assign ndac = q.ctl_s2[L_NDAC];
  assign btn_press = q.booted & q.ctl_s2[L_BTN] & ~q.btn_prev;
  assign cmd = q.dio_s2[6:0];
  // Switch four carries weight 16, switch eight weight 1; an off switch adds its weight.
  assign sw_addr = {~q.sw_s2[3], ~q.sw_s2[4], ~q.sw_s2[5], ~q.sw_s2[6], ~q.sw_s2[7]};
  // Except in talker-only mode the device takes part in command handshakes; data only when addressed to listen.
  assign ah_active = q.booted & ~q.talker_only & (atn | q.listen);
  assign data_send_ok = ~atn & q.tx_full & ((q.talk & ~q.spoll_mode) | (q.talker_only & q.reading));
  assign poll_send_ok = ~atn & q.talk & q.spoll_mode & ~q.talker_only;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    d = q;
    ev_set = 4'h0;
    d.ctl_s1 = {panel_button, ~bus_in_n.eoi, ~bus_in_n.ndac, ~bus_in_n.nrfd,
                ~bus_in_n.dav, ~bus_in_n.ren, ~bus_in_n.ifc, ~bus_in_n.atn};
    d.ctl_s2 = q.ctl_s1;
    d.dio_s1 = ~bus_in_n.dio;
    d.dio_s2 = q.dio_s1;
    d.sw_s1 = setup_sw_on;
    d.sw_s2 = q.sw_s1;
    d.btn_prev = q.ctl_s2[L_BTN];
    d.lvl = '0;

    // Switches are taken once, after the synchroniser has filled, and then held.
    if (!q.booted) begin
      d.boot_cnt = q.boot_cnt + 2'h1;
      if (q.boot_cnt == SW_SETTLE_CYCLES) begin
        d.booted = 1'b1;
        d.talker_only = ~q.sw_s2[0];
        d.my_addr = (sw_addr == 5'h00) ? DEFAULT_ADDR : sw_addr;
      end
    end

    // Acceptor handshake: NDAC held while ready, NRFD held while no room; both released while inactive.
    if (!ah_active) begin
      d.ah = AH_READY;
      d.oe.nrfd = 1'b0;
      d.oe.ndac = 1'b0;
    end else begin
      unique case (q.ah)
        AH_READY: begin
          d.oe.ndac = 1'b1;
          d.oe.nrfd = ~atn & q.rx_full;
          if (dav && !q.oe.nrfd) begin
            d.ah = AH_HOLD;
            d.oe.nrfd = 1'b1;
            d.oe.ndac = 1'b0;
            if (atn) begin
              // Parallel poll, controller and secondary addresses are not decoded.
              if (cmd[6:5] == GRP_LISTEN) begin
                if (cmd == CMD_UNL) begin
                  d.listen = 1'b0;
                end else if (cmd[4:0] == q.my_addr) begin
                  d.listen = 1'b1;
                  d.remote = q.remote | ren;
                end
              end else if (cmd[6:5] == GRP_TALK) begin
                d.talk = (cmd != CMD_UNT) && (cmd[4:0] == q.my_addr);
              end else begin
                unique case (cmd)
                  CMD_GTL: d.remote = q.listen ? 1'b0 : q.remote;
                  CMD_SDC: ev_set[EV_CLEAR] = q.listen;
                  CMD_GET: ev_set[EV_TRIGGER] = q.listen;
                  CMD_LLO: d.lockout = q.lockout | ren;
                  CMD_DCL: ev_set[EV_CLEAR] = 1'b1;
                  CMD_SPE: d.spoll_mode = 1'b1;
                  CMD_SPD: d.spoll_mode = 1'b0;
                  default: d.spoll_mode = q.spoll_mode;
                endcase
              end
            end else if (q.listen && !q.rx_full) begin
              d.rx_data = q.dio_s2;
              d.rx_eoi = q.ctl_s2[L_EOI];
              d.rx_full = 1'b1;
            end
          end
        end
        AH_HOLD: begin
          if (!dav) begin
            d.ah = AH_READY;
            d.oe.ndac = 1'b1;
          end
        end
        default: d.ah = AH_READY;
      endcase
    end

    // Source handshake: data settle time, then DAV until all acceptors take it.
    unique case (q.sh)
      SH_IDLE: begin
        if (data_send_ok || poll_send_ok) begin
          d.sh = SH_SETTLE;
          d.settle_cnt = 8'h00;
          d.sh_is_poll = ~data_send_ok;
          d.oe.dio = data_send_ok ? q.tx_data : {q.spoll_byte[7], q.srq_req, q.spoll_byte[5:0]};
          d.oe.eoi = data_send_ok & q.tx_eoi;
        end
      end
      SH_SETTLE: begin
        if (q.settle_cnt != 8'(SETTLE_CYCLES)) begin
          d.settle_cnt = q.settle_cnt + 8'h01;
        end
        if (atn && !q.talker_only) begin
          d.sh = SH_IDLE;
          d.oe.dio = 8'h00;
          d.oe.eoi = 1'b0;
        end else if (q.settle_cnt == 8'(SETTLE_CYCLES) && !nrfd) begin
          d.sh = SH_WAIT;
          d.oe.dav = 1'b1;
        end
      end
      SH_WAIT: begin
        if (!ndac) begin
          d.sh = SH_IDLE;
          d.oe.dav = 1'b0;
          d.oe.dio = 8'h00;
          d.oe.eoi = 1'b0;
          if (q.sh_is_poll) begin
            d.srq_req = 1'b0;
          end else begin
            d.tx_full = 1'b0;
            if (q.talker_only && q.tx_eoi) begin
              d.reading = 1'b0;
              d.pulse_cnt = 24'(LISTEN_PULSE_CYCLES);
              ev_set[EV_SENT] = 1'b1;
            end
          end
        end
      end
      default: d.sh = SH_IDLE;
    endcase

    if (q.pulse_cnt != 24'h00_0000) begin
      d.pulse_cnt = (d.pulse_cnt == 24'(LISTEN_PULSE_CYCLES) && q.sh == SH_WAIT) ? d.pulse_cnt
                                                                                : q.pulse_cnt - 24'h00_0001;
    end

    // Front-panel button.
    if (btn_press) begin
      if (q.talker_only) begin
        if (!q.reading) begin
          d.reading = 1'b1;
          ev_set[EV_TRIGGER] = 1'b1;
        end
      end else if (!q.lockout) begin
        ev_set[EV_BUTTON] = 1'b1;
      end
    end

    // Interface clear and loss of remote enable.
    if (ifc) begin
      d.talk = 1'b0;
      d.listen = 1'b0;
      d.spoll_mode = 1'b0;
    end
    if (!ren) begin
      d.remote = 1'b0;
      d.lockout = 1'b0;
    end
    d.oe.srq = q.booted & ~q.talker_only & d.srq_req;
    d.events = q.events | ev_set;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave. An event set by hardware in the cycle of its clear wins.

    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      unique case (q.aw_addr)
        OFF_CTRL: begin
          if (q.wstrb[0]) begin
            d.srq_req = q.wdata[0];
          end
        end
        OFF_STATUS, OFF_RXDATA: d.bresp = RESP_OKAY;
        OFF_TXDATA: begin
          if (q.wstrb[0] && !q.tx_full) begin
            d.tx_data = q.wdata[7:0];
            d.tx_eoi = q.wstrb[1] & q.wdata[8];
            d.tx_full = 1'b1;
          end
        end
        OFF_EVENTS: begin
          if (q.wstrb[0]) begin
            d.events = (q.events & ~q.wdata[3:0]) | ev_set;
          end
        end
        OFF_SPOLL: begin
          if (q.wstrb[0]) begin
            d.spoll_byte = q.wdata[7:0];
          end
        end
        default: d.bresp = RESP_SLVERR;
      endcase
    end

    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFF_CTRL: d.rdata[0] = q.srq_req;
        OFF_STATUS: d.rdata[12:0] = {q.my_addr, q.spoll_mode, q.rx_full, q.tx_full, q.talker_only,
                                     q.lockout, q.talk, q.listen, q.remote};
        OFF_TXDATA: d.rdata[8:0] = {q.tx_eoi, q.tx_data};
        OFF_RXDATA: begin
          d.rdata[9:0] = {q.rx_full, q.rx_eoi, q.rx_data};
          d.rx_full = 1'b0;
        end
        OFF_EVENTS: d.rdata[3:0] = q.events;
        OFF_SPOLL: d.rdata[7:0] = {q.spoll_byte[7], q.srq_req, q.spoll_byte[5:0]};
        default: d.rresp = RESP_SLVERR;
      endcase
    end
    d.awready = ~d.aw_got & ~d.bvalid;
    d.wready = ~d.w_got & ~d.bvalid;
    d.arready = ~d.rvalid;

    // Indicators.
    d.led.remote = d.remote;
    d.led.listen = d.listen | (d.pulse_cnt != 24'h00_0000);
    d.led.talk = d.talk | d.talker_only;
    d.led.lockout = d.lockout;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign bus_out = q.lvl;
  assign bus_oe = q.oe;
  assign leds = q.led;

endmodule

// ===== gpib_device_interface_chk.sv
`timescale 1ns/1ps
module gpib_device_interface_chk import gpib_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write response
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Bus pins and indicators
  input wire bus_lines_type bus_in_n,
  input wire bus_lines_type bus_out,
  input wire bus_lines_type bus_oe,
  input wire leds_type leds
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_open_collector: assert property (bus_out == '0)
    else $error("bus line driven high");
  a_no_controller: assert property (!bus_oe.atn && !bus_oe.ifc && !bus_oe.ren)
    else $error("controller line pulled");
  a_talk_sources: assert property (bus_oe.dav |-> leds.talk)
    else $error("data sourced without talk");
  a_data_held: assert property (bus_oe.dav && $past(bus_oe.dav) |-> $stable(bus_oe.dio) && $stable(bus_oe.eoi))
    else $error("data moved under DAV");
  a_dav_settled: assert property ($rose(bus_oe.dav) |-> $past(bus_oe.dio, 8) == bus_oe.dio)
    else $error("DAV before data settled");
  a_dav_ready: assert property ($rose(bus_oe.dav) |-> $past(bus_in_n.nrfd))
    else $error("DAV while NRFD asserted");
  a_dav_release: assert property ($fell(bus_oe.dav) |-> $past(bus_in_n.ndac) || !$past(bus_in_n.atn))
    else $error("DAV dropped before NDAC released");
  // Going idle releases NDAC with DAV false; only an accept with DAV true must hold NRFD.
  a_accept_order: assert property ($fell(bus_oe.ndac) && !bus_in_n.dav |-> bus_oe.nrfd)
    else $error("NDAC released before NRFD held");
  a_lockout_ren: assert property ($rose(leds.lockout) |-> !bus_in_n.ren)
    else $error("lockout without REN");
  a_remote_ren: assert property ($rose(leds.remote) |-> !bus_in_n.ren)
    else $error("remote without REN");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  c_source: cover property ($rose(bus_oe.dav));
  c_accept: cover property ($fell(bus_oe.ndac));
  c_lockout: cover property ($rose(leds.lockout));
  c_listen: cover property ($rose(leds.listen));
endmodule

bind gpib_device_interface gpib_device_interface_chk chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .bus_in_n(bus_in_n), .bus_out(bus_out), .bus_oe(bus_oe), .leds(leds)
);

// ===== gpib_partner.sv
`timescale 1ns/1ps
module gpib_partner import gpib_pkg::*; (
  // Clock
  input wire logic aclk,
  // Device drive
  input wire bus_lines_type dev_out,
  input wire bus_lines_type dev_oe,
  // Resolved wires, low means asserted
  output bus_lines_type wire_n
);
  bus_lines_type src_pull = '0;
  bus_lines_type acc_pull = '0;
  logic lsn = 1'b0;
  logic [1:0] phase = 2'h0;
  int lag = 0;
  int hold = 0;
  int rx_cnt = 0;
  logic [7:0] rx_byte = 8'h00;
  logic rx_eoi = 1'b0;

  // Released lines float high through the cable terminations.
  assign wire_n = bus_lines_type'(~((dev_oe & ~dev_out) | src_pull | acc_pull));

  ////////////////////////////////////////
  // Listener; lag holds NDAC longer, as a slow printer would.
  always @(posedge aclk) begin
    if (!lsn) begin
      acc_pull <= '0;
      phase <= 2'h0;
    end else if (phase == 2'h0) begin
      acc_pull.ndac <= 1'b1;
      if (!wire_n.dav && acc_pull.ndac) begin
        rx_byte <= ~wire_n.dio;
        rx_eoi <= ~wire_n.eoi;
        rx_cnt <= rx_cnt + 1;
        acc_pull.nrfd <= 1'b1;
        hold <= 0;
        phase <= 2'h1;
      end
    end else if (phase == 2'h1) begin
      hold <= hold + 1;
      if (hold >= lag) begin
        acc_pull.ndac <= 1'b0;
        phase <= 2'h2;
      end
    end else if (wire_n.dav) begin
      acc_pull.ndac <= 1'b1;
      acc_pull.nrfd <= 1'b0;
      phase <= 2'h0;
    end
  end

  // Controller source; waits are bounded so a silent acceptor cannot hang the run.
  task automatic send(input logic atn, input logic [7:0] b, input logic eoi);
    int n;
    n = 0;
    @(posedge aclk);
    src_pull.atn <= atn;
    src_pull.dio <= b;
    src_pull.eoi <= eoi;
    repeat (4) @(posedge aclk);
    while (wire_n.nrfd !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    src_pull.dav <= 1'b1;
    @(posedge aclk);
    while (wire_n.ndac !== 1'b1 && n < 6000) begin
      @(posedge aclk);
      n++;
    end
    src_pull.dav <= 1'b0;
    src_pull.dio <= 8'h00;
    src_pull.eoi <= 1'b0;
    repeat (8) @(posedge aclk);
    src_pull.atn <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask

  task automatic set_ren(input logic v);
    @(posedge aclk);
    src_pull.ren <= v;
    repeat (8) @(posedge aclk);
  endtask

  task automatic pulse_ifc();
    @(posedge aclk);
    src_pull.ifc <= 1'b1;
    repeat (8) @(posedge aclk);
    src_pull.ifc <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
endmodule

// ===== gpib_device_interface_test.sv
`timescale 1ns/1ps
module gpib_device_interface_test import gpib_pkg::*;;
  localparam int PULSE = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_ADDR_W-1:0] awaddr = '0;
  logic [AXI_ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] setup_sw = 8'h00;
  logic [3:0] wstrb = 4'hF;
  logic button = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, got;
  bus_lines_type bus_in_n, bus_out, bus_oe;
  leds_type leds;
  int miscompares = 0;
  int comparisons = 0;
  int n = 0;

  always #5 aclk = ~aclk;

  gpib_device_interface #(.LISTEN_PULSE_CYCLES(PULSE)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bus_in_n(bus_in_n), .bus_out(bus_out), .bus_oe(bus_oe),
    .setup_sw_on(setup_sw), .panel_button(button), .leds(leds)
  );

  gpib_partner p (.aclk(aclk), .dev_out(bus_out), .dev_oe(bus_oe), .wire_n(bus_in_n));

  ////////////////////////////////////////
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic axi_write(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        resp = bresp;
      end
    end
    bready <= 1'b0;
    check_val({31'h0, done}, 32'h0000_0001);
  endtask

  task automatic axi_read(input logic [AXI_ADDR_W-1:0] a);
    logic done;
    done = 1'b0;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        got = rdata;
        resp = rresp;
      end
    end
    rready <= 1'b0;
    check_val({31'h0, done}, 32'h0000_0001);
  endtask

  task automatic read_chk(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
    axi_read(a);
    check_val(got & m, e);
  endtask

  // Switches are only latched after reset, so every mode change goes through here.
  task automatic reset_with(input logic [7:0] sw);
    @(posedge aclk);
    aresetn <= 1'b0;
    setup_sw <= sw;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
  endtask

  task automatic press();
    @(posedge aclk);
    button <= 1'b1;
    repeat (8) @(posedge aclk);
    button <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask

  task automatic expect_byte(input int cnt, input logic [8:0] e);
    n = 0;
    while (p.rx_cnt < cnt && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    check_val({23'h0, p.rx_eoi, p.rx_byte}, {23'h0, e});
  endtask

  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    reset_with(8'hF9);
    read_chk(OFF_STATUS, 32'h0000_0600, 32'hFFFF_FFFF);
    read_chk(OFF_EVENTS, 32'h0000_0000, 32'hFFFF_FFFF);
    reset_with(8'h00);
    // The status talk bit is the addressed state; talker-only has its own status bit and lights the talk indicator.
    read_chk(OFF_STATUS, 32'h0000_1F10, 32'hFFFF_FFFF);
    check_val({28'h0, leds}, 32'h0000_0002);
    setup_sw <= 8'h31;
    press();
    read_chk(OFF_STATUS, 32'h0000_1F10, 32'hFFFF_FFFF);
    read_chk(OFF_EVENTS, 32'h0000_0001, 32'hFFFF_FFFF);
    axi_write(OFF_EVENTS, 32'h0000_0001);
    p.lsn = 1'b1;
    p.lag = 30;
    axi_write(OFF_TXDATA, 32'h0000_01C3);
    expect_byte(1, 9'h1C3);
    n = 0;
    while (leds.listen !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    check_val({28'h0, leds}, 32'h0000_0006);
    repeat (PULSE + 4) @(posedge aclk);
    check_val({28'h0, leds}, 32'h0000_0002);
    read_chk(OFF_EVENTS, 32'h0000_0008, 32'hFFFF_FFFF);
    axi_write(OFF_TXDATA, 32'h0000_01B7);
    repeat (400) @(posedge aclk);
    check_val(p.rx_cnt, 32'h0000_0001);
    p.lsn = 1'b0;
    reset_with(8'h31);
    read_chk(OFF_STATUS, 32'h0000_1300, 32'hFFFF_FFFF);
    p.set_ren(1'b1);
    p.send(1'b1, 8'h33, 1'b0);
    check_val({28'h0, leds}, 32'h0000_000C);
    p.send(1'b0, 8'h5A, 1'b1);
    read_chk(OFF_RXDATA, 32'h0000_035A, 32'h0000_03FF);
    p.send(1'b1, {1'b0, CMD_LLO}, 1'b0);
    check_val({28'h0, leds}, 32'h0000_000D);
    press();
    p.send(1'b1, {1'b0, CMD_GET}, 1'b0);
    p.send(1'b1, {1'b0, CMD_SDC}, 1'b0);
    read_chk(OFF_EVENTS, 32'h0000_0003, 32'hFFFF_FFFF);
    axi_write(OFF_EVENTS, 32'h0000_000F);
    p.send(1'b1, {1'b0, CMD_DCL}, 1'b0);
    read_chk(OFF_EVENTS, 32'h0000_0002, 32'hFFFF_FFFF);
    axi_write(OFF_EVENTS, 32'h0000_000F);
    p.set_ren(1'b0);
    check_val({28'h0, leds}, 32'h0000_0004);
    press();
    read_chk(OFF_EVENTS, 32'h0000_0004, 32'hFFFF_FFFF);
    axi_write(OFF_EVENTS, 32'h0000_000F);
    p.set_ren(1'b1);
    p.send(1'b1, 8'h33, 1'b0);
    p.send(1'b1, {1'b0, CMD_GTL}, 1'b0);
    check_val({28'h0, leds}, 32'h0000_0004);
    p.send(1'b1, {1'b0, CMD_UNL}, 1'b0);
    p.send(1'b0, 8'h77, 1'b0);
    read_chk(OFF_RXDATA, 32'h0000_0000, 32'h0000_0200);
    p.send(1'b1, 8'h53, 1'b0);
    check_val({28'h0, leds}, 32'h0000_0002);
    p.lsn = 1'b1;
    // Without the second byte strobe the EOI request bit must not be taken.
    wstrb <= 4'h1;
    axi_write(OFF_TXDATA, 32'h0000_01A5);
    expect_byte(2, 9'h0A5);
    wstrb <= 4'hF;
    p.lag = 0;
    axi_write(OFF_SPOLL, 32'h0000_0005);
    axi_write(OFF_CTRL, 32'h0000_0001);
    repeat (4) @(posedge aclk);
    check_val({30'h0, bus_oe.srq, bus_in_n.srq}, 32'h0000_0002);
    p.lsn = 1'b0;
    p.send(1'b1, {1'b0, CMD_SPE}, 1'b0);
    p.lsn = 1'b1;
    expect_byte(3, 9'h045);
    p.lsn = 1'b0;
    p.send(1'b1, {1'b0, CMD_SPD}, 1'b0);
    check_val({31'h0, bus_oe.srq}, 32'h0000_0000);
    p.pulse_ifc();
    check_val({28'h0, leds}, 32'h0000_0000);
    axi_read(5'h18);
    check_val({got[29:0], resp}, {30'h0, RESP_SLVERR});
    axi_write(5'h1C, 32'hFFFF_FFFF);
    check_val({30'h0, resp}, {30'h0, RESP_SLVERR});
    final_report();
  end

  initial begin
    #1_000_000;
    miscompares++;
    final_report();
  end
endmodule
